// ==== lmcb_pkg.sv ====
// Shared constants and types for the LCD mode, clock and boost control block
package lmcb_pkg;
	// Register addresses
	localparam logic [15:0] LMCB_ADDR_MODE = 16'h0001;
	localparam logic [15:0] LMCB_ADDR_CLK = 16'h0002;
	localparam logic [15:0] LMCB_ADDR_BOOST = 16'h0003;
	localparam logic [15:0] LMCB_ADDR_CKSEL = 16'hff40;
	// Reset value, shared by all four registers
	localparam logic [7:0] LMCB_REG_RESET = 8'h00;
	// Writable bits; the rest are stored and read as zero
	localparam logic [7:0] LMCB_MODE_MASK = 8'he7;
	localparam logic [7:0] LMCB_CLK_MASK = 8'h0f;
	localparam logic [7:0] LMCB_BOOST_MASK = 8'hc1;
	localparam logic [7:0] LMCB_CKSEL_MASK = 8'h1f;
	// Field positions in display_mode_ctrl
	localparam int LMCB_DISP_ON_BIT = 7;
	localparam int LMCB_DRIVE_BIT = 6;
	localparam int LMCB_BOOST_BIT = 5;
	localparam int LMCB_MODE_LSB = 0;
	// Field positions in lcd_clock_ctrl
	localparam int LMCB_SRC_LSB = 2;
	localparam int LMCB_DIV_LSB = 0;
	// Field positions in boost_contrast_ctrl
	localparam int LMCB_GAIN_BIT = 0;
	localparam int LMCB_CONTRAST_LSB = 6;
	// Field positions in host_clock_output_select
	localparam int LMCB_CLKOUT_EN_BIT = 4;
	localparam int LMCB_CCS_LSB = 0;
	// Output clock select codes
	localparam logic [3:0] LMCB_CCS_PRS_64 = 4'h6;
	localparam logic [3:0] LMCB_CCS_PRS_128 = 4'h7;
	localparam logic [3:0] LMCB_CCS_SUB = 4'h8;
	// Last count of the peripheral clock prescaler
	localparam logic [6:0] LMCB_PRS_LAST_64 = 7'h3f;
	localparam logic [6:0] LMCB_PRS_LAST_128 = 7'h7f;
	// Source clock select codes and prescaler last counts
	localparam logic [1:0] LMCB_SRC_DIV2 = 2'h2;
	localparam logic [1:0] LMCB_SRC_DIV4 = 2'h3;
	localparam logic [1:0] LMCB_SRC_LAST_2 = 2'h1;
	localparam logic [1:0] LMCB_SRC_LAST_4 = 2'h3;
	// Last counts of the LCD clock divider, by divide code
	localparam logic [8:0] LMCB_DIV_LAST_64 = 9'h03f;
	localparam logic [8:0] LMCB_DIV_LAST_128 = 9'h07f;
	localparam logic [8:0] LMCB_DIV_LAST_256 = 9'h0ff;
	localparam logic [8:0] LMCB_DIV_LAST_512 = 9'h1ff;
	// Display mode codes
	localparam logic [2:0] LMCB_MODE_4S_B3 = 3'h0;
	localparam logic [2:0] LMCB_MODE_3S_B3 = 3'h1;
	localparam logic [2:0] LMCB_MODE_2S_B2 = 3'h2;
	localparam logic [2:0] LMCB_MODE_3S_B2 = 3'h3;
	localparam logic [2:0] LMCB_MODE_STATIC = 3'h4;
	// Time slice counts
	localparam logic [2:0] LMCB_SLICES_1 = 3'h1;
	localparam logic [2:0] LMCB_SLICES_2 = 3'h2;
	localparam logic [2:0] LMCB_SLICES_3 = 3'h3;
	localparam logic [2:0] LMCB_SLICES_4 = 3'h4;
	// Segment and common drive state
	typedef enum logic [1:0] {
		LMCB_DRV_GROUND,
		LMCB_DRV_DESELECT,
		LMCB_DRV_DISPLAY
	} lmcb_drive_type;
endpackage : lmcb_pkg

// ==== lmcb_sync3.sv ====
// Three-flop synchroniser with rising-edge pulse for an outside clock
module lmcb_sync3 (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Outside level and its qualified rising edge
	input wire logic i_async,
	output logic o_rise
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;
	logic agree_w;

	// Only the second and third stages are compared
	assign agree_w = (s2_r == s3_r);

	// Synchroniser chain and filtered level
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
			o_rise <= 1'b0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (agree_w) begin
				level_r <= s3_r;
			end
			o_rise <= agree_w & s3_r & ~level_r;
		end
	end
endmodule : lmcb_sync3

// ==== lmcb_ctrl.sv ====
// LCD display mode, clock chain and boost control registers
module lmcb_ctrl
	import lmcb_pkg::*;
(
	// Clock (peripheral clock) and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Register access port
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	// Clock sources, gating and reference generator select
	input wire logic i_sub_clk,
	input wire logic i_port_mode_clock_gate,
	input wire logic [1:0] i_ref_generator_select,
	// Driver control outputs
	output logic [1:0] o_drive_state,
	output logic o_boost_run,
	output logic o_gain,
	output logic [1:0] o_contrast_select,
	output logic [2:0] o_slices,
	output logic o_bias_half,
	output logic o_mode_prohibited,
	// Timing outputs
	output logic o_clock_out_tick,
	output logic o_lcd_clock_tick,
	output logic o_frame_tick,
	output logic [1:0] o_com_index
);
	// Mode decode: {slices, bias_half, prohibited}
	function automatic logic [4:0] mode_decode(input logic [2:0] code, input logic boosting);
		logic [4:0] res;
		res = {LMCB_SLICES_4, 1'b0, 1'b1};
		if (boosting) begin
			case (code)
				LMCB_MODE_4S_B3, LMCB_MODE_2S_B2: res = {LMCB_SLICES_4, 1'b0, 1'b0};
				LMCB_MODE_3S_B3, LMCB_MODE_3S_B2: res = {LMCB_SLICES_3, 1'b0, 1'b0};
				default: res = {LMCB_SLICES_4, 1'b0, 1'b1};
			endcase
		end else begin
			case (code)
				LMCB_MODE_4S_B3: res = {LMCB_SLICES_4, 1'b0, 1'b0};
				LMCB_MODE_3S_B3: res = {LMCB_SLICES_3, 1'b0, 1'b0};
				LMCB_MODE_2S_B2: res = {LMCB_SLICES_2, 1'b1, 1'b0};
				LMCB_MODE_3S_B2: res = {LMCB_SLICES_3, 1'b1, 1'b0};
				LMCB_MODE_STATIC: res = {LMCB_SLICES_1, 1'b0, 1'b0};
				default: res = {LMCB_SLICES_4, 1'b0, 1'b1};
			endcase
		end
		return res;
	endfunction : mode_decode

	logic [7:0] mode_r;
	logic [7:0] clk_r;
	logic [7:0] boost_r;
	logic [7:0] cksel_r;
	logic [6:0] prs_cnt_r;
	logic [1:0] src_cnt_r;
	logic [8:0] div_cnt_r;
	logic [1:0] slice_r;
	logic sub_rise_w;

	// Subsystem clock arrives from outside the domain
	lmcb_sync3 u_sub_sync (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_async(i_sub_clk),
		.o_rise(sub_rise_w)
	);

	// Register decode
	wire sel_mode_w = (i_addr == LMCB_ADDR_MODE);
	wire sel_clk_w = (i_addr == LMCB_ADDR_CLK);
	wire sel_boost_w = (i_addr == LMCB_ADDR_BOOST);
	wire sel_cksel_w = (i_addr == LMCB_ADDR_CKSEL);
	wire [7:0] rdata_w = sel_mode_w ? mode_r :
		sel_clk_w ? clk_r :
		sel_boost_w ? boost_r :
		sel_cksel_w ? cksel_r : 8'h00;

	// Register fields
	wire display_on_w = mode_r[LMCB_DISP_ON_BIT];
	wire drive_w = mode_r[LMCB_DRIVE_BIT];
	wire boost_w = mode_r[LMCB_BOOST_BIT];
	wire [2:0] mode_code_w = mode_r[LMCB_MODE_LSB +: 3];
	wire [1:0] src_sel_w = clk_r[LMCB_SRC_LSB +: 2];
	wire [1:0] div_sel_w = clk_r[LMCB_DIV_LSB +: 2];
	wire [3:0] ccs_w = cksel_r[LMCB_CCS_LSB +: 4];
	wire clkout_en_w = cksel_r[LMCB_CLKOUT_EN_BIT];

	// Reference generator picks the decode table
	wire boosting_w = i_ref_generator_select[1];
	wire [4:0] mode_dec_w = mode_decode(mode_code_w, boosting_w);
	wire [2:0] slices_w = mode_dec_w[4:2];

	// Output clock: peripheral clock prescaled or subsystem clock
	wire prs_last_w = (ccs_w == LMCB_CCS_PRS_64) ? (prs_cnt_r[5:0] == LMCB_PRS_LAST_64[5:0]) :
		(prs_cnt_r == LMCB_PRS_LAST_128);
	wire gate_open_w = clkout_en_w & ~i_port_mode_clock_gate;
	wire pcl_tick_w = gate_open_w & ((ccs_w == LMCB_CCS_SUB) ? sub_rise_w :
		((ccs_w == LMCB_CCS_PRS_64) | (ccs_w == LMCB_CCS_PRS_128)) & prs_last_w);

	// Source prescale by 1, 2 or 4
	wire src_tick_w = pcl_tick_w & ((src_sel_w == LMCB_SRC_DIV2) ?
		(src_cnt_r[0] == LMCB_SRC_LAST_2[0]) :
		(src_sel_w == LMCB_SRC_DIV4) ? (src_cnt_r == LMCB_SRC_LAST_4) : 1'b1);

	// LCD clock divider by 64 to 512
	wire [8:0] div_last_w = (div_sel_w == 2'h0) ? LMCB_DIV_LAST_64 :
		(div_sel_w == 2'h1) ? LMCB_DIV_LAST_128 :
		(div_sel_w == 2'h2) ? LMCB_DIV_LAST_256 : LMCB_DIV_LAST_512;
	wire lcd_tick_w = src_tick_w & ((div_cnt_r & div_last_w) == div_last_w);

	// Slice counter wraps after the mode's slice count
	wire slice_wrap_w = (slice_r == 2'(slices_w - LMCB_SLICES_1)) |
		(slice_r > 2'(slices_w - LMCB_SLICES_1));
	wire frame_w = lcd_tick_w & slice_wrap_w;

	// Drive state: ground beats deselect beats display
	lmcb_drive_type drive_nxt;
	assign drive_nxt = !drive_w ? LMCB_DRV_GROUND :
		!display_on_w ? LMCB_DRV_DESELECT : LMCB_DRV_DISPLAY;

	// Register file; unused bits kept at zero
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_r <= LMCB_REG_RESET;
			clk_r <= LMCB_REG_RESET;
			boost_r <= LMCB_REG_RESET;
			cksel_r <= LMCB_REG_RESET;
		end else if (i_wr_en) begin
			if (sel_mode_w) mode_r <= i_wdata & LMCB_MODE_MASK;
			if (sel_clk_w) clk_r <= i_wdata & LMCB_CLK_MASK;
			if (sel_boost_w) boost_r <= i_wdata & LMCB_BOOST_MASK;
			if (sel_cksel_w) cksel_r <= i_wdata & LMCB_CKSEL_MASK;
		end
	end

	// Read data registered one cycle after the strobe
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
		end else begin
			o_rdata <= i_rd_en ? rdata_w : 8'h00;
			o_rvalid <= i_rd_en;
		end
	end

	// Divider chain; counters clear to zero while the clock output is gated
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			prs_cnt_r <= 7'h00;
			src_cnt_r <= 2'h0;
			div_cnt_r <= 9'h000;
			slice_r <= 2'h0;
		end else if (!gate_open_w) begin
			prs_cnt_r <= 7'h00;
			src_cnt_r <= 2'h0;
			div_cnt_r <= 9'h000;
			slice_r <= 2'h0;
		end else begin
			prs_cnt_r <= prs_last_w ? 7'h00 : prs_cnt_r + 7'h01;
			if (pcl_tick_w) src_cnt_r <= src_cnt_r + 2'h1;
			if (src_tick_w) div_cnt_r <= div_cnt_r + 9'h001;
			if (lcd_tick_w) slice_r <= slice_wrap_w ? 2'h0 : slice_r + 2'h1;
		end
	end

	// Registered outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_drive_state <= LMCB_DRV_GROUND;
			o_boost_run <= 1'b0;
			o_gain <= 1'b0;
			o_contrast_select <= 2'h0;
			o_slices <= LMCB_SLICES_4;
			o_bias_half <= 1'b0;
			o_mode_prohibited <= 1'b0;
			o_clock_out_tick <= 1'b0;
			o_lcd_clock_tick <= 1'b0;
			o_frame_tick <= 1'b0;
			o_com_index <= 2'h0;
		end else begin
			o_drive_state <= drive_nxt;
			o_boost_run <= boost_w;
			o_gain <= boost_r[LMCB_GAIN_BIT];
			o_contrast_select <= boost_r[LMCB_CONTRAST_LSB +: 2];
			o_slices <= slices_w;
			o_bias_half <= mode_dec_w[1];
			o_mode_prohibited <= mode_dec_w[0];
			o_clock_out_tick <= pcl_tick_w;
			o_lcd_clock_tick <= lcd_tick_w;
			o_frame_tick <= frame_w;
			o_com_index <= slice_r;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	// Helper: cycles since the last LCD clock tick
	logic [15:0] gap_r;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) gap_r <= 16'h0000;
		else if (lcd_tick_w || !gate_open_w) gap_r <= 16'h0000;
		else gap_r <= gap_r + 16'h0001;
	end

	drive_ground_a: assert property (!drive_w |=> o_drive_state == LMCB_DRV_GROUND)
		else $error("pins not grounded with drive off");
	drive_deselect_a: assert property (
		drive_w && !display_on_w |=> o_drive_state == LMCB_DRV_DESELECT)
		else $error("segments not deselected with display off");
	boost_follow_a: assert property (##1 o_boost_run == $past(mode_r[LMCB_BOOST_BIT]))
		else $error("booster output does not follow enable");
	static_mode_a: assert property (
		!boosting_w && mode_code_w == LMCB_MODE_STATIC
		|=> o_slices == LMCB_SLICES_1 && !o_mode_prohibited)
		else $error("static mode decode wrong");
	boost_mode_a: assert property (
		boosting_w && mode_code_w == LMCB_MODE_2S_B2
		|=> o_slices == LMCB_SLICES_4 && !o_bias_half)
		else $error("boosting mode decode wrong");
	clock_gate_a: assert property (!clkout_en_w || i_port_mode_clock_gate |=> !o_clock_out_tick)
		else $error("clock forwarded while gated");
	prs64_rate_a: assert property (
		pcl_tick_w && ccs_w == LMCB_CCS_PRS_64 && $stable(cksel_r) && gate_open_w
		##1 (gate_open_w && $stable(cksel_r))[*8] |-> !pcl_tick_w)
		else $error("output clock by 64 ticks too early");
	// Source select 0x means undivided, so only the high select bit matters
	lcd_div_a: assert property (
		lcd_tick_w && !src_sel_w[1] && ccs_w == LMCB_CCS_PRS_64
		|-> gap_r >= 16'd63 || $changed(clk_r) || $changed(cksel_r))
		else $error("LCD clock faster than divide setting");
	frame_wrap_a: assert property (o_frame_tick |-> o_com_index == 2'(o_slices - LMCB_SLICES_1))
		else $error("frame tick not at last slice");
	reset_mode_a: assert property ($rose(i_resetn) |-> mode_r == LMCB_REG_RESET)
		else $error("mode register not cleared by reset");
endmodule : lmcb_ctrl

// ==== lmcb_host_model.sv ====
// Host core model: register port driver and free running subsystem clock
module lmcb_host_model
	import lmcb_pkg::*;
(
	// Clock
	input wire logic i_clk,
	// Register port towards the block
	output logic o_wr_en,
	output logic o_rd_en,
	output logic [15:0] o_addr,
	output logic [7:0] o_wdata,
	input wire logic [7:0] i_rdata,
	input wire logic i_rvalid,
	// Subsystem oscillator, 16 cycles a period, off phase
	output logic o_sub_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle port, oscillator runs free as a crystal does
	initial begin
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 8'h00;
		o_sub_clk = 1'b0;
		#7;
		forever #320 o_sub_clk = ~o_sub_clk;
	end
	// Bits the host may set; the rest are written as zero
	function automatic logic [7:0] keep(input logic [15:0] a);
		case (a)
			LMCB_ADDR_MODE: keep = LMCB_MODE_MASK;
			LMCB_ADDR_CLK: keep = LMCB_CLK_MASK;
			LMCB_ADDR_BOOST: keep = LMCB_BOOST_MASK;
			default: keep = LMCB_CKSEL_MASK;
		endcase
	endfunction : keep
	// Data is scrambled once released so stale values cannot pass
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_wr_en <= 1'b1;
		o_addr <= a;
		o_wdata <= d & keep(a);
		@(posedge i_clk);
		o_wr_en <= 1'b0;
		o_wdata <= ~o_wdata;
	endtask : wr
	// Read answer is taken the cycle after the strobe edge
	task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
		@(posedge i_clk);
		o_rd_en <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd_en <= 1'b0;
		o_addr <= ~o_addr;
		#1;
		d = i_rdata;
		v = i_rvalid;
	endtask : rd
endmodule : lmcb_host_model

// ==== lcd_mode_clock_boost_control_bench.sv ====
// Self-checking bench for the LCD mode, clock and boost control block
module lcd_mode_clock_boost_control_bench
	import lmcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk, i_resetn, gate, wr_en, rd_en, sub_clk, rvalid, boost, gain, bias_half, prohib;
	logic pcl_t, lcd_t, frame_t, v;
	logic [1:0] ref_sel, drive, contrast, com_idx;
	logic [2:0] slices;
	logic [15:0] addr;
	logic [7:0] wdata, rdata, d;
	int fails, n_checks;
	// Design and host
	lmcb_ctrl uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wr_en(wr_en), .i_rd_en(rd_en),
		.i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rvalid(rvalid),
		.i_sub_clk(sub_clk), .i_port_mode_clock_gate(gate), .i_ref_generator_select(ref_sel),
		.o_drive_state(drive), .o_boost_run(boost), .o_gain(gain),
		.o_contrast_select(contrast), .o_slices(slices), .o_bias_half(bias_half),
		.o_mode_prohibited(prohib), .o_clock_out_tick(pcl_t), .o_lcd_clock_tick(lcd_t),
		.o_frame_tick(frame_t), .o_com_index(com_idx));
	lmcb_host_model host (.i_clk(i_clk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr),
		.o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rvalid), .o_sub_clk(sub_clk));
	// 25 MHz clock
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// Derived outputs lag a write by one more edge
	task automatic settle;
		repeat (2) @(posedge i_clk);
		#1;
	endtask : settle
	function automatic logic pick(input int s);
		return s == 0 ? pcl_t : (s == 1 ? lcd_t : frame_t);
	endfunction : pick
	// Cycles between two ticks; first tick may be partial after a change
	task automatic period(input int s, output int n);
		// Skip ticks still launched by the old setting
		settle();
		n = 0;
		while (pick(s) !== 1'b1 && n < 20000) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		n = 0;
		do begin
			@(posedge i_clk);
			#1;
			n++;
		end while (pick(s) !== 1'b1 && n < 20000);
	endtask : period
	task automatic quiet(output int k);
		k = 0;
		settle();
		repeat (300) begin
			@(posedge i_clk);
			#1;
			if (pcl_t !== 1'b0) k++;
		end
	endtask : quiet
	task automatic t_reset;
		logic [15:0] regs [4] = '{LMCB_ADDR_MODE, LMCB_ADDR_CLK, LMCB_ADDR_BOOST, LMCB_ADDR_CKSEL};
		for (int i = 0; i < 4; i++) begin
			host.rd(regs[i], d, v);
			chk({7'h00, v, d}, 16'h0100);
		end
		chk({10'h000, drive, boost, slices}, {10'h000, 2'(LMCB_DRV_GROUND), 1'b0, 3'h4});
	endtask : t_reset
	// Boost on, drive, display, then back down in the allowed order
	task automatic t_power;
		logic [7:0] seq [6] = '{8'h20, 8'h60, 8'he0, 8'h60, 8'h20, 8'h00};
		logic [2:0] exp [6] = '{3'b001, 3'b011, 3'b101, 3'b011, 3'b001, 3'b000};
		@(posedge i_clk);
		ref_sel <= 2'h2;
		for (int i = 0; i < 6; i++) begin
			host.wr(LMCB_ADDR_MODE, seq[i]);
			settle();
			chk({13'h0000, drive, boost}, {13'h0000, exp[i]});
		end
	endtask : t_power
	task automatic t_boost_reg;
		host.wr(LMCB_ADDR_BOOST, 8'h81);
		settle();
		chk({13'h0000, gain, contrast}, 16'h0006);
		host.rd(LMCB_ADDR_BOOST, d, v);
		chk({7'h00, v, d}, 16'h0181);
		host.wr(LMCB_ADDR_BOOST, 8'h40);
		settle();
		chk({13'h0000, gain, contrast}, 16'h0001);
		host.rd(16'h0004, d, v);
		chk({7'h00, v, d}, 16'h0100);
	endtask : t_boost_reg
	// Mode codes 0 to 5 under every reference generator setting
	task automatic t_modes;
		logic [2:0] rs [6] = '{3'h4, 3'h3, 3'h2, 3'h3, 3'h1, 3'h4};
		logic [2:0] es;
		logic eh, ep;
		for (int r = 0; r < 4; r++) begin
			@(posedge i_clk);
			ref_sel <= 2'(r);
			for (int c = 0; c < 6; c++) begin
				host.wr(LMCB_ADDR_MODE, 8'(c));
				settle();
				es = r > 1 ? ((c == 1 || c == 3) ? 3'h3 : 3'h4) : rs[c];
				eh = r < 2 && (c == 2 || c == 3);
				ep = c > 4 || (r > 1 && c == 4);
				chk({11'h000, slices, bias_half, prohib}, {11'h000, es, eh, ep});
			end
		end
	endtask : t_modes
	task automatic t_clocks;
		int n;
		@(posedge i_clk);
		gate <= 1'b0;
		host.wr(LMCB_ADDR_CKSEL, 8'h16);
		period(0, n);
		chk(16'(n), 16'd64);
		host.wr(LMCB_ADDR_CKSEL, 8'h17);
		period(0, n);
		chk(16'(n), 16'd128);
		@(posedge i_clk);
		gate <= 1'b1;
		quiet(n);
		chk(16'(n), 16'd0);
		@(posedge i_clk);
		gate <= 1'b0;
		host.wr(LMCB_ADDR_CKSEL, 8'h06);
		quiet(n);
		chk(16'(n), 16'd0);
		host.wr(LMCB_ADDR_CKSEL, 8'h18);
		period(0, n);
		chk(16'(n), 16'd16);
		// Booster stays off while the clock register changes; source stays above 32 kHz
		host.wr(LMCB_ADDR_CKSEL, 8'h16);
		host.wr(LMCB_ADDR_CLK, 8'h04);
		period(1, n);
		chk(16'(n), 16'd4096);
		host.wr(LMCB_ADDR_CLK, 8'h01);
		period(1, n);
		chk(16'(n), 16'd8192);
		host.wr(LMCB_ADDR_CLK, 8'h08);
		period(1, n);
		chk(16'(n), 16'd8192);
		// Gate the output first so the slice count restarts before the mode change
		@(posedge i_clk);
		ref_sel <= 2'h1;
		host.wr(LMCB_ADDR_CKSEL, 8'h06);
		host.wr(LMCB_ADDR_CLK, 8'h04);
		// Time is compressed: only the slowest settings keep frames under 128 Hz
		host.wr(LMCB_ADDR_MODE, 8'h01);
		host.wr(LMCB_ADDR_CKSEL, 8'h16);
		period(2, n);
		chk(16'(n), 16'd12288);
		chk({14'h0000, com_idx}, 16'h0002);
	endtask : t_clocks
	// Main sequence
	initial begin
		fails = 0;
		n_checks = 0;
		gate = 1'b0;
		ref_sel = 2'h0;
		i_resetn = 1'b0;
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_power();
		t_boost_reg();
		t_modes();
		// Mid-run reset must clear the registers written above
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_resetn <= 1'b1;
		t_reset();
		t_clocks();
		tally_and_finish();
	end
	// Watchdog, well beyond the 65k cycles the clock tests need
	initial begin
		#(90000 * 40);
		fails++;
		tally_and_finish();
	end
endmodule : lcd_mode_clock_boost_control_bench
